// ===== hw/apc_pad_ctrl.sv
// module: pad control bank for clock, frame-sync and first interrupt pins with resync
//
// Behaviour
// [RQ1] master clock pull-down follows its bit 1
// [RQ2] master clock strong drive follows its bit 0
// [RQ3] bit clock pull-down follows its bit 1
// [RQ4] bit clock strong drive follows its bit 0
// [RQ5] writing resync 1 then 0 restarts datapath
// [RQ6] resync acts only in sync or audio mode
// [RQ7] frame-sync pull-down follows its bit 1
// [RQ8] frame-sync strong drive follows its bit 0
// [RQ9] bit 7 sets interrupt pin polarity, high default
// [RQ10] interrupt pin pull-down follows its bit 1
// [RQ11] interrupt pin strong drive follows its bit 0
// [RQ12] reserved bits read zero, registers read back
`timescale 1ns/1ns

module apc_pad_ctrl
  import apc_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // internal register port from the serial control interface
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rd_valid,
  // operating modes from the clock and serial port configuration
  input  wire logic       external_sample_sync,
  input  wire logic       audio_output_mode,
  // interrupt event from the interrupt mapping logic, active high
  input  wire logic       first_irq_event,
  // pad controls
  output logic            master_clock_pulldown_en,
  output logic            master_clock_strong_drive,
  output logic            bit_clock_pulldown_en,
  output logic            bit_clock_strong_drive,
  output logic            frame_sync_pulldown_en,
  output logic            frame_sync_strong_drive,
  output logic            first_irq_pulldown_en,
  output logic            first_irq_strong_drive,
  // pin level and datapath restart
  output logic            first_interrupt_pin,
  output logic            datapath_resync
);

  // ****************************************************************
  // address decode
  // ****************************************************************

  // match of an access against one register offset
  function automatic logic apc_hit(input logic       en,
                                   input logic [7:0] addr,
                                   input logic [7:0] offs);
    apc_hit = en && (addr == offs);
  endfunction : apc_hit

  localparam logic [7:0] OFFS  [APC_NUM_REGS] = '{APC_MASTER_CLOCK_PAD_OFFS,
                                                   APC_BIT_CLOCK_PAD_OFFS,
                                                   APC_FRAME_SYNC_PAD_OFFS,
                                                   APC_FIRST_IRQ_PAD_OFFS};
  localparam logic [7:0] WMASK [APC_NUM_REGS] = '{APC_MASTER_CLOCK_PAD_WMASK,
                                                   APC_BIT_CLOCK_PAD_WMASK,
                                                   APC_FRAME_SYNC_PAD_WMASK,
                                                   APC_FIRST_IRQ_PAD_WMASK};

  logic [APC_NUM_REGS-1:0] wr_hit;
  logic [APC_NUM_REGS-1:0] rd_hit;
  logic [7:0]              pad_q   [APC_NUM_REGS];
  logic [7:0]              rd_term [APC_NUM_REGS];

  // ****************************************************************
  // pad registers
  // ****************************************************************

  // one masked register per offset, read terms gated by decode
  generate
    for (genvar i = 0; i < APC_NUM_REGS; i++)
    begin : g_reg
      assign wr_hit[i]  = apc_hit(reg_wr_en, reg_addr, OFFS[i]);
      assign rd_hit[i]  = apc_hit(reg_rd_en, reg_addr, OFFS[i]);
      assign rd_term[i] = rd_hit[i] ? pad_q[i] : 8'h00;

      apc_pad_reg #(
        .WMASK   (WMASK[i]),
        .RST_VAL (APC_PAD_REG_RESET)
      ) u_pad_reg (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .wr_en   (wr_hit[i]),
        .wdata   (reg_wdata),
        .q_r     (pad_q[i])
      );

      // reserved positions never hold a one
      rsvd_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ12]
        (pad_q[i] & ~WMASK[i]) == 8'h00)
        else $error("reserved pad register bit is set");
    end
  endgenerate

  // pad control outputs are taken straight from the register flops
  assign master_clock_pulldown_en  = pad_q[0][APC_PULLDOWN_BIT];     // see [RQ1]
  assign master_clock_strong_drive = pad_q[0][APC_STRONG_DRIVE_BIT]; // see [RQ2]
  assign bit_clock_pulldown_en     = pad_q[1][APC_PULLDOWN_BIT];     // see [RQ3]
  assign bit_clock_strong_drive    = pad_q[1][APC_STRONG_DRIVE_BIT]; // see [RQ4]
  assign frame_sync_pulldown_en    = pad_q[2][APC_PULLDOWN_BIT];     // see [RQ7]
  assign frame_sync_strong_drive   = pad_q[2][APC_STRONG_DRIVE_BIT]; // see [RQ8]
  assign first_irq_pulldown_en     = pad_q[3][APC_PULLDOWN_BIT];     // see [RQ10]
  assign first_irq_strong_drive    = pad_q[3][APC_STRONG_DRIVE_BIT]; // see [RQ11]

  // ****************************************************************
  // read path
  // ****************************************************************

  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       rd_valid_r;
  logic       rd_any;

  // unmapped addresses leave the read data unchanged and give no valid
  assign rd_any    = |rd_hit;
  assign rdata_nxt = rd_any ? (rd_term[0] | rd_term[1] | rd_term[2] | rd_term[3]) : rdata_r;

  // read data register, held between reads
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      rdata_r    <= APC_RDATA_RESET;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      rdata_r    <= rdata_nxt; // see [RQ12]
      rd_valid_r <= rd_any;
    end
  end

  assign reg_rdata    = rdata_r;
  assign reg_rd_valid = rd_valid_r;

  // ****************************************************************
  // interrupt pin polarity
  // ****************************************************************

  logic first_irq_polarity;
  logic irq_pin_r;
  logic irq_pin_nxt;

  // zero keeps the pin active high, one inverts it to active low
  assign first_irq_polarity = pad_q[3][APC_POLARITY_BIT];
  assign irq_pin_nxt        = first_irq_event ^ first_irq_polarity; // see [RQ9]

  // pin level flop
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      irq_pin_r <= 1'b0;
    else
      irq_pin_r <= irq_pin_nxt;
  end

  assign first_interrupt_pin = irq_pin_r;

  // ****************************************************************
  // forced resynchronization
  // ****************************************************************

  apc_rs_state_t rs_state_r;
  apc_rs_state_t rs_state_nxt;
  logic          resync_bit;
  logic          resync_mode_ok;
  logic          resync_r;

  assign resync_bit     = pad_q[2][APC_RESYNC_BIT];
  assign resync_mode_ok = external_sample_sync | audio_output_mode; // see [RQ6]

  // arm on a one, fire on the return to zero if sync or audio mode is on
  always_comb
  begin
    rs_state_nxt = rs_state_r;
    case (rs_state_r)
      APC_RS_IDLE:
        if (resync_bit)
          rs_state_nxt = APC_RS_ARMED;
      APC_RS_ARMED:
        if (!resync_bit)
          rs_state_nxt = resync_mode_ok ? APC_RS_FIRE : APC_RS_IDLE; // see [RQ5]
      APC_RS_FIRE:
        rs_state_nxt = resync_bit ? APC_RS_ARMED : APC_RS_IDLE;
      default:
        rs_state_nxt = APC_RS_IDLE;
    endcase
  end

  // state and one-cycle restart pulse
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      rs_state_r <= APC_RS_IDLE;
      resync_r   <= 1'b0;
    end
    else
    begin
      rs_state_r <= rs_state_nxt;
      resync_r   <= (rs_state_nxt == APC_RS_FIRE); // see [RQ5]
    end
  end

  assign datapath_resync = resync_r;

  // ****************************************************************
  // checks
  // ****************************************************************

  master_clock_pulldown_en_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ1]
    wr_hit[0] |=> master_clock_pulldown_en == $past(reg_wdata[1]))
    else $error("master clock pull-down not taken from write");

  master_clock_strong_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ2]
    !wr_hit[0] |=> $stable(master_clock_strong_drive) && $stable(master_clock_pulldown_en))
    else $error("master clock pad control changed without write");

  mclk_wr_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ2]
    wr_hit[0] |=> master_clock_strong_drive == $past(reg_wdata[0]))
    else $error("master clock strong drive not taken from write");

  bit_clock_pulldown_en_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ3]
    wr_hit[1] |=> bit_clock_pulldown_en == $past(reg_wdata[1]))
    else $error("bit clock pull-down not taken from write");

  bit_clock_strong_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ4]
    wr_hit[1] |=> bit_clock_strong_drive == $past(reg_wdata[0]))
    else $error("bit clock strong drive not taken from write");

  resync_fire_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ5]
    ($fell(resync_bit) && resync_mode_ok) |=> datapath_resync ##1 !datapath_resync)
    else $error("resync pulse missing or longer than one cycle");

  resync_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ6]
    datapath_resync |-> $past(resync_mode_ok) && !$past(resync_bit))
    else $error("resync fired outside sync or audio mode");

  fs_pd_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ7]
    wr_hit[2] |=> frame_sync_pulldown_en == $past(reg_wdata[1]))
    else $error("frame-sync pull-down not taken from write");

  fs_drv_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ8]
    wr_hit[2] |=> frame_sync_strong_drive == $past(reg_wdata[0]))
    else $error("frame-sync strong drive not taken from write");

  irq_pol_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ9]
    1'b1 |=> first_interrupt_pin == ($past(first_irq_event) ^ $past(first_irq_polarity)))
    else $error("interrupt pin level does not follow polarity");

  irq_pd_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ10]
    wr_hit[3] |=> first_irq_pulldown_en == $past(reg_wdata[1]))
    else $error("interrupt pull-down not taken from write");

  irq_drv_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ11]
    wr_hit[3] |=> first_irq_strong_drive == $past(reg_wdata[0]))
    else $error("interrupt strong drive not taken from write");

  read_back_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see [RQ12]
    (rd_hit[2] && !reg_wr_en) |=> reg_rd_valid && reg_rdata == $past(pad_q[2]))
    else $error("frame-sync register read back wrong");

endmodule : apc_pad_ctrl

// ===== hw/apc_pkg.sv
// package: offsets, field layout, reset values and state encoding of the pad control bank
package apc_pkg;

  // ****************************************************************
  // register offsets on the internal register port
  // ****************************************************************
  localparam logic [7:0] APC_MASTER_CLOCK_PAD_OFFS  = 8'h5A;
  localparam logic [7:0] APC_BIT_CLOCK_PAD_OFFS     = 8'h5B;
  localparam logic [7:0] APC_FRAME_SYNC_PAD_OFFS    = 8'h5C;
  localparam logic [7:0] APC_FIRST_IRQ_PAD_OFFS     = 8'h5D;

  // number of pad registers in the bank
  localparam int         APC_NUM_REGS               = 4;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int         APC_STRONG_DRIVE_BIT       = 0;
  localparam int         APC_PULLDOWN_BIT           = 1;
  localparam int         APC_RESYNC_BIT             = 7;
  localparam int         APC_POLARITY_BIT           = 7;

  // ****************************************************************
  // writable bits per register; all others are reserved and read zero
  // ****************************************************************
  localparam logic [7:0] APC_MASTER_CLOCK_PAD_WMASK = 8'h03;
  localparam logic [7:0] APC_BIT_CLOCK_PAD_WMASK    = 8'h03;
  localparam logic [7:0] APC_FRAME_SYNC_PAD_WMASK   = 8'h83;
  localparam logic [7:0] APC_FIRST_IRQ_PAD_WMASK    = 8'h83;

  // ****************************************************************
  // values after reset
  // ****************************************************************
  localparam logic [7:0] APC_PAD_REG_RESET          = 8'h00;
  localparam logic [7:0] APC_RDATA_RESET            = 8'h00;

  // ****************************************************************
  // forced resynchronization sequencer, gray along idle-armed-fire
  // ****************************************************************
  typedef enum logic [1:0] {
    APC_RS_IDLE  = 2'h0,
    APC_RS_ARMED = 2'h1,
    APC_RS_FIRE  = 2'h3
  } apc_rs_state_t;

endpackage : apc_pkg

// ===== hw/apc_pad_reg.sv
// module: one byte-wide pad register with a write mask for reserved bits
`timescale 1ns/1ns

module apc_pad_reg
  import apc_pkg::*;
#(
  parameter logic [7:0] WMASK    = 8'hFF,
  parameter logic [7:0] RST_VAL  = 8'h00
)
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // write side
  input  wire logic       wr_en,
  input  wire logic [7:0] wdata,
  // stored value
  output logic      [7:0] q_r
);

  logic [7:0] q_nxt;

  // reserved bits are forced to zero, the rest take the written data
  assign q_nxt = wr_en ? (wdata & WMASK) : q_r;

  // storage
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      q_r <= RST_VAL & WMASK;
    else
      q_r <= q_nxt;
  end

endmodule : apc_pad_reg

// ===== verif/apc_host_model.sv
// host model: drives the internal register port as the control interface would
`timescale 1ns/1ns

module apc_host_model
(
  // clock
  input  wire logic       sys_clk,
  // register port toward the bank
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  // read answer
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rd_valid
);
  // idle bus at time zero
  initial
  begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // one write strobe; released lines show the inverse so stale values cannot match
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge sys_clk);
    reg_wr_en = 1'b1;
    reg_addr  = addr;
    reg_wdata = data;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
    reg_addr  = ~addr;
    reg_wdata = ~data;
  endtask : write_reg

  // one read strobe; answer sampled in the cycle after the taking edge
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
                          output logic valid);
    @(negedge sys_clk);
    reg_rd_en = 1'b1;
    reg_addr  = addr;
    @(negedge sys_clk);
    reg_rd_en = 1'b0;
    reg_addr  = ~addr;
    data      = reg_rdata;
    valid     = reg_rd_valid;
  endtask : read_reg

endmodule : apc_host_model

// ===== verif/tb.sv
// testbench: self-checking scenarios for the pad control bank
`timescale 1ns/1ns

module tb;
  import apc_pkg::*;
  // ****************************************************************
  // signals, counters and instances
  // ****************************************************************
  logic       sys_clk, rst_b, reg_wr_en, reg_rd_en, reg_rd_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       external_sample_sync, audio_output_mode, first_irq_event;
  wire  [7:0] pads;
  logic       first_interrupt_pin, datapath_resync;
  int         mismatches, tests_run, cycles;
  logic [7:0] masks [4] = '{APC_MASTER_CLOCK_PAD_WMASK, APC_BIT_CLOCK_PAD_WMASK,
                            APC_FRAME_SYNC_PAD_WMASK, APC_FIRST_IRQ_PAD_WMASK};

  apc_pad_ctrl apc_pad_ctrl_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .external_sample_sync(external_sample_sync),
    .audio_output_mode(audio_output_mode), .first_irq_event(first_irq_event),
    .master_clock_pulldown_en(pads[7]), .master_clock_strong_drive(pads[6]),
    .bit_clock_pulldown_en(pads[5]), .bit_clock_strong_drive(pads[4]),
    .frame_sync_pulldown_en(pads[3]), .frame_sync_strong_drive(pads[2]),
    .first_irq_pulldown_en(pads[1]), .first_irq_strong_drive(pads[0]),
    .first_interrupt_pin(first_interrupt_pin), .datapath_resync(datapath_resync));

  apc_host_model apc_host_model_i (
    .sys_clk(sys_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid));

  // ****************************************************************
  // checking and closing
  // ****************************************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  // read one register and compare data and valid
  task automatic read_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    apc_host_model_i.read_reg(addr, d, v);
    chk("read valid", 8'h01, {7'h00, v});
    chk("read data", exp, d);
  endtask : read_chk

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // every register reads zero after reset, pads idle
  task automatic reset_test();
    chk("pads after reset", 8'h00, pads);
    for (int i = 0; i < 4; i++)
      read_chk(8'h5A + 8'(i), APC_PAD_REG_RESET);
  endtask : reset_test

  // all ones then all zeros: reserved bits drop, pad outputs follow, no resync when modes off
  task automatic pad_bits_test();
    for (int i = 0; i < 4; i++)
      apc_host_model_i.write_reg(8'h5A + 8'(i), 8'hFF);
    chk("pads all set", 8'hFF, pads);
    for (int i = 0; i < 4; i++)
      read_chk(8'h5A + 8'(i), masks[i]);
    for (int i = 0; i < 4; i++)
    begin
      apc_host_model_i.write_reg(8'h5A + 8'(i), 8'h00);
      // a pulse would stand in the cycle after the next edge, look there
      @(negedge sys_clk);
      chk("resync modes off", 8'h00, {7'h00, datapath_resync});
    end
    @(negedge sys_clk);
    chk("resync modes off late", 8'h00, {7'h00, datapath_resync});
    chk("pads all clear", 8'h00, pads);
    read_chk(8'h5C, 8'h00);
  endtask : pad_bits_test

  // unmapped address gives no valid answer
  task automatic unmapped_test();
    logic [7:0] d;
    logic       v;
    apc_host_model_i.read_reg(8'h59, d, v);
    chk("unmapped valid", 8'h00, {7'h00, v});
  endtask : unmapped_test

  // resync toggle under sync only, audio only and neither mode; one pulse one cycle after the zero write is taken
  task automatic resync_test();
    logic [1:0] modes [3] = '{2'b10, 2'b01, 2'b00};
    foreach (modes[m])
    begin
      {external_sample_sync, audio_output_mode} = modes[m];
      apc_host_model_i.write_reg(8'h5C, 8'h80);
      apc_host_model_i.write_reg(8'h5C, 8'h00);
      chk("resync early", 8'h00, {7'h00, datapath_resync});
      @(negedge sys_clk);
      chk("resync pulse", {7'h00, |modes[m]}, {7'h00, datapath_resync});
      @(negedge sys_clk);
      chk("resync end", 8'h00, {7'h00, datapath_resync});
    end
    {external_sample_sync, audio_output_mode} = 2'b00;
  endtask : resync_test

  // interrupt pin level for both polarities and both event levels
  task automatic irq_pin_test();
    for (int p = 0; p < 2; p++)
    begin
      apc_host_model_i.write_reg(8'h5D, p[0] ? 8'h80 : 8'h00);
      for (int e = 0; e < 2; e++)
      begin
        first_irq_event = e[0];
        @(negedge sys_clk);
        chk("irq pin", {7'h00, e[0] ^ p[0]}, {7'h00, first_interrupt_pin});
      end
      first_irq_event = 1'b0;
    end
  endtask : irq_pin_test

  // ****************************************************************
  // clock, timeout and main sequence
  // ****************************************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      complete_run();
    end
  end

  initial
  begin
    {rst_b, external_sample_sync, audio_output_mode, first_irq_event} = 4'h0;
    {mismatches, tests_run, cycles} = '0;
    repeat (16) @(negedge sys_clk);
    rst_b = 1'b1;
    reset_test();
    pad_bits_test();
    unmapped_test();
    resync_test();
    irq_pin_test();
    complete_run();
  end

endmodule : tb
